// ===== logic/css_buf2.sv
// two-entry stroke word buffer with valid and ready on both sides
// assumes the filling side holds its word while ready is low
`default_nettype none
module css_buf2 (
    input wire logic clk_in,
    input wire logic reset_in,
    css_word_if.snk fill,
    css_word_if.src drain
);
    typedef struct packed {
        css_pkg::css_word_t [1:0] mem;
        logic head;
        logic [1:0] cnt;
    } css_buf_s;

    css_buf_s s_r;
    css_buf_s s_nxt;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // handshakes
    assign fill.ready = (s_r.cnt != 2'h2);
    assign drain.valid = (s_r.cnt != 2'h0);
    assign drain.data = s_r.mem[s_r.head];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.head ^ s_r.cnt[0]] = fill.data;
        end
        if (pop) begin
            s_nxt.head = ~s_r.head;
        end
        s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    no_overfill_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (s_r.cnt == 2'h2 && !pop) |=> s_r.cnt == 2'h2)
        else $error("buffer lost a word");
endmodule
`default_nettype wire

// ===== logic/css_pkg.sv
// constants, state codes and stroke word layout for the character stroke sequencer
// assumes a single 20 MHz clock and a synchronous active-high reset
`default_nettype none
package css_pkg;
    // clock and travel timing
    localparam int CLK_NS = 50;
    localparam int STEP_NS = 100;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int NL_NS = 2000;
    localparam int NL_CYC = (NL_NS + CLK_NS - 1) / CLK_NS;
    localparam int DLY_W = 8;
    // stroke counter
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_LAST = 3'h7;
    // cursor underline
    localparam logic [2:0] CSR_X_ODD = 3'h6;
    localparam logic [2:0] CSR_X_EVEN = 3'h0;
    localparam logic [2:0] CSR_Y = 3'h0;
    localparam logic [2:0] CSR_END_CNT = 3'h5;
    // stroke word fields
    localparam int WORD_W = 8;
    localparam int SW_END = 7;
    localparam int SW_BLANK = 6;
    localparam int SW_X_HI = 5;
    localparam int SW_X_LO = 3;
    localparam int SW_Y_HI = 2;
    localparam int SW_Y_LO = 0;
    typedef logic [WORD_W-1:0] css_word_t;
    // main beam geometry
    localparam int POS_W = 10;
    localparam logic [POS_W-1:0] X_SP_NORM = 10'h010;
    localparam logic [POS_W-1:0] X_SP_LARGE = 10'h018;
    localparam logic [POS_W-1:0] Y_SP_NORM = 10'h020;
    localparam logic [POS_W-1:0] Y_SP_LARGE = 10'h030;
    localparam logic [POS_W:0] X_LIMIT = 11'h3F0;
    localparam logic [POS_W-1:0] X_HOME = 10'h000;
    localparam logic [POS_W-1:0] Y_TOP = 10'h3E0;
    // character sequencer states
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_DRAW = 6'h02,
        S_CURSOR = 6'h04,
        S_CHECK = 6'h08,
        S_NEWL = 6'h10,
        S_MOVE = 6'h20
    } css_state_e;
endpackage
`default_nettype wire

// ===== logic/css_top.sv
// stroke counter, stroke register and character sequencer of a stroke character generator
// assumes stroke timer, character analysis and converters share sys_clk_in
`default_nettype none
// What this block does
// - a 3-bit counter 0..7 plus first-stroke latch sequences up to nine strokes
// - stroke counter advances each time the stroke sampling pulse ends
// - first stroke of each character comes from the first-stroke latch
// - final stroke carries an end marker that starts the character ending sequence
// - counter reaching 7 clears the ninth-stroke hold; next step wraps to zero
// - count zero with hold clear enables stroke nine, which presents an end bit
// - decoding-complete latch sets the hold again, dropping the end bit
// - end bit on a later stroke starts ending and returns counter to zero
// - single-stroke character leaves counter alone; first sample clears first latch
// - stroke register holds X, Y, blank and end bits for the yoke converters
// - next beam position is computed in the check state after the character (and any cursor) is drawn
// - codes are fetched by service cycles or buffer cycles per source
// - found code starts drawing and stores spacing from the size multiplier
// - on deflection permit, no overflow loads X add and waits travel delay
// - X overflow forces a new line and stores the downward step
// - new line without underflow steps Y down and clears X to the margin
// - Y underflow places the next matrix at the upper-left corner
// - beam in place sets deflection-complete, letting strokes start
// - a blank code is positioned exactly like a printable character
// - cursor bit after drawing defers overflow check and connects the cursor
// - cursor strokes 1,3,5 go to X6 Y0, 2,4,6 to X0 Y0, end on 6
// - after the cursor the deferred checks run and the beam moves on
// - strokes are unblanked unless the blank bit is present
module css_top (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic decode_timing_pulse_in,
    input wire logic char_valid_in,
    input wire logic char_cursor_in,
    input wire logic char_newline_in,
    input wire logic size_multiplier_latch_in,
    input wire logic buffer_mode_in,
    input wire logic sample_end_in,
    input wire logic [2:0] stroke_x_in,
    input wire logic [2:0] stroke_y_in,
    input wire logic stroke_blank_in,
    input wire logic stroke_end_in,
    input wire logic dac_ready_in,
    output logic sample_ready_out,
    output logic start_draw_out,
    output logic fetch_service_out,
    output logic fetch_buffer_out,
    output logic first_stroke_out,
    output logic [2:0] stroke_count_out,
    output logic stroke_nine_out,
    output logic cursor_connect_out,
    output logic deflection_complete_out,
    output logic [9:0] x_defl_out,
    output logic [9:0] y_defl_out,
    output logic [7:0] stroke_reg_out,
    output logic dac_valid_out,
    output logic [2:0] dac_x_out,
    output logic [2:0] dac_y_out,
    output logic dac_blank_out,
    output logic dac_end_out
);
    typedef struct packed {
        css_pkg::css_state_e fsm;
        logic first;
        logic [2:0] cnt;
        logic hold9;
        logic end_l;
        logic dec_done;
        logic cursor_conn;
        logic csr_pend;
        logic nl_pend;
        logic big;
        logic start_p;
        logic fetch_s;
        logic fetch_b;
        logic defl_done;
        logic [css_pkg::POS_W-1:0] x_sum;
        logic [css_pkg::POS_W-1:0] y_sum;
        logic [css_pkg::POS_W-1:0] x_defl;
        logic [css_pkg::POS_W-1:0] y_defl;
        logic [css_pkg::DLY_W-1:0] dly;
        css_pkg::css_word_t stroke_reg;
    } css_top_s;

    css_top_s s_r;
    css_top_s s_nxt;
    css_pkg::css_word_t word;
    logic stroke9;
    logic take;
    logic accept;
    logic overflow;

    css_word_if fill_if ();
    css_word_if drain_if ();

    ////////////////////////////////////////////////////////////////////////
    // cursor stroke pattern
    function automatic css_pkg::css_word_t cursor_word(input logic first,
                                                       input logic [2:0] cnt);
        css_pkg::css_word_t w;
        w = '0;
        w[css_pkg::SW_X_HI:css_pkg::SW_X_LO] =
            cnt[0] ? css_pkg::CSR_X_EVEN : css_pkg::CSR_X_ODD;
        w[css_pkg::SW_Y_HI:css_pkg::SW_Y_LO] = css_pkg::CSR_Y;
        w[css_pkg::SW_END] = !first && (cnt == css_pkg::CSR_END_CNT);
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // stroke selection
    assign stroke9 = !s_r.first && (s_r.cnt == css_pkg::CNT_ZERO) && !s_r.hold9;
    assign take = sample_end_in && fill_if.ready && !s_r.end_l
        && (s_r.fsm == css_pkg::S_DRAW || s_r.fsm == css_pkg::S_CURSOR);
    assign accept = (s_r.fsm == css_pkg::S_IDLE) && decode_timing_pulse_in && char_valid_in;
    assign overflow = s_r.nl_pend
        || ({1'b0, s_r.x_defl} + {1'b0, s_r.x_sum} > css_pkg::X_LIMIT);

    always_comb begin
        if (s_r.cursor_conn) begin
            word = cursor_word(s_r.first, s_r.cnt);
        end else begin
            word = '0;
            word[css_pkg::SW_END] = stroke_end_in || stroke9;
            word[css_pkg::SW_BLANK] = stroke_blank_in;
            word[css_pkg::SW_X_HI:css_pkg::SW_X_LO] = stroke9 ? 3'h0 : stroke_x_in;
            word[css_pkg::SW_Y_HI:css_pkg::SW_Y_LO] = stroke9 ? 3'h0 : stroke_y_in;
        end
    end

    assign fill_if.valid = take;
    assign fill_if.data = word;
    assign sample_ready_out = fill_if.ready;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.start_p = 1'b0;
        s_nxt.fetch_s = 1'b0;
        s_nxt.fetch_b = 1'b0;
        // stroke counter and latches
        if (take) begin
            s_nxt.stroke_reg = word;
            s_nxt.first = 1'b0;
            if (word[css_pkg::SW_END]) begin
                s_nxt.end_l = 1'b1;
                if (!s_r.first) begin
                    s_nxt.cnt = css_pkg::CNT_ZERO;
                end
            end else begin
                s_nxt.cnt = s_r.cnt + 3'h1;
                if (s_r.cnt + 3'h1 == css_pkg::CNT_LAST) begin
                    s_nxt.hold9 = 1'b0;
                end
            end
        end
        if (s_r.end_l) begin
            s_nxt.dec_done = 1'b1;
        end
        if (s_r.dec_done) begin
            s_nxt.hold9 = 1'b1;
        end
        // character sequencer
        unique case (s_r.fsm)
            css_pkg::S_IDLE: begin
                if (accept) begin
                    s_nxt.fetch_s = !buffer_mode_in;
                    s_nxt.fetch_b = buffer_mode_in;
                    s_nxt.big = size_multiplier_latch_in;
                    s_nxt.x_sum = size_multiplier_latch_in ?
                        css_pkg::X_SP_LARGE : css_pkg::X_SP_NORM;
                    s_nxt.csr_pend = char_cursor_in;
                    s_nxt.nl_pend = char_newline_in;
                    s_nxt.defl_done = 1'b0;
                    if (char_newline_in) begin
                        s_nxt.fsm = css_pkg::S_CHECK;
                    end else begin
                        s_nxt.start_p = 1'b1;
                        s_nxt.first = 1'b1;
                        s_nxt.cnt = css_pkg::CNT_ZERO;
                        s_nxt.hold9 = 1'b1;
                        s_nxt.end_l = 1'b0;
                        s_nxt.dec_done = 1'b0;
                        s_nxt.fsm = css_pkg::S_DRAW;
                    end
                end
            end
            css_pkg::S_DRAW: begin
                if (s_r.end_l && s_r.csr_pend) begin
                    s_nxt.csr_pend = 1'b0;
                    s_nxt.cursor_conn = 1'b1;
                    s_nxt.start_p = 1'b1;
                    s_nxt.first = 1'b1;
                    s_nxt.cnt = css_pkg::CNT_ZERO;
                    s_nxt.hold9 = 1'b1;
                    s_nxt.end_l = 1'b0;
                    s_nxt.dec_done = 1'b0;
                    s_nxt.fsm = css_pkg::S_CURSOR;
                end else if (s_r.end_l) begin
                    s_nxt.fsm = css_pkg::S_CHECK;
                end
            end
            css_pkg::S_CURSOR: begin
                if (s_r.end_l) begin
                    s_nxt.cursor_conn = 1'b0;
                    s_nxt.fsm = css_pkg::S_CHECK;
                end
            end
            css_pkg::S_CHECK: begin
                if (overflow) begin
                    s_nxt.y_sum = s_r.big ?
                        css_pkg::Y_SP_LARGE : css_pkg::Y_SP_NORM;
                    s_nxt.fsm = css_pkg::S_NEWL;
                end else begin
                    s_nxt.x_defl = s_r.x_defl + s_r.x_sum;
                    s_nxt.dly = css_pkg::DLY_W'(s_r.x_sum * css_pkg::STEP_CYC);
                    s_nxt.fsm = css_pkg::S_MOVE;
                end
            end
            css_pkg::S_NEWL: begin
                s_nxt.nl_pend = 1'b0;
                s_nxt.x_defl = css_pkg::X_HOME;
                if (s_r.y_defl >= s_r.y_sum) begin
                    s_nxt.y_defl = s_r.y_defl - s_r.y_sum;
                end else begin
                    s_nxt.y_defl = css_pkg::Y_TOP;
                end
                s_nxt.dly = css_pkg::DLY_W'(css_pkg::NL_CYC);
                s_nxt.fsm = css_pkg::S_MOVE;
            end
            css_pkg::S_MOVE: begin
                if (s_r.dly == '0) begin
                    s_nxt.defl_done = 1'b1;
                    s_nxt.fsm = css_pkg::S_IDLE;
                end else begin
                    s_nxt.dly = s_r.dly - css_pkg::DLY_W'(1);
                end
            end
            default: begin
                s_nxt.fsm = css_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            s_r <= '0;
            s_r.fsm <= css_pkg::S_IDLE;
            s_r.hold9 <= 1'b1;
            s_r.defl_done <= 1'b1;
            s_r.y_defl <= css_pkg::Y_TOP;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output buffer toward the converters
    css_buf2 u_buf (
        .clk_in(sys_clk_in),
        .reset_in(reset_in),
        .fill(fill_if.snk),
        .drain(drain_if.src)
    );

    assign drain_if.ready = dac_ready_in;
    assign dac_valid_out = drain_if.valid;
    assign dac_x_out = drain_if.data[css_pkg::SW_X_HI:css_pkg::SW_X_LO];
    assign dac_y_out = drain_if.data[css_pkg::SW_Y_HI:css_pkg::SW_Y_LO];
    assign dac_blank_out = drain_if.data[css_pkg::SW_BLANK];
    assign dac_end_out = drain_if.data[css_pkg::SW_END];

    ////////////////////////////////////////////////////////////////////////
    // status outputs
    assign start_draw_out = s_r.start_p;
    assign fetch_service_out = s_r.fetch_s;
    assign fetch_buffer_out = s_r.fetch_b;
    assign first_stroke_out = s_r.first;
    assign stroke_count_out = s_r.cnt;
    assign stroke_nine_out = stroke9;
    assign cursor_connect_out = s_r.cursor_conn;
    assign deflection_complete_out = s_r.defl_done;
    assign x_defl_out = s_r.x_defl;
    assign y_defl_out = s_r.y_defl;
    assign stroke_reg_out = s_r.stroke_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    count_step_a: assert property (
        take && !word[css_pkg::SW_END] |=> s_r.cnt == $past(s_r.cnt) + 3'h1)
        else $error("stroke counter did not step");
    first_latch_a: assert property (
        accept && !char_newline_in |=> first_stroke_out && stroke_count_out == 3'h0)
        else $error("first stroke latch not set");
    nine_hold_a: assert property (
        take && !word[css_pkg::SW_END] && s_r.cnt == 3'h6 |=> s_r.cnt == 3'h7 && !s_r.hold9)
        else $error("hold latch not cleared at count 7");
    nine_end_a: assert property (
        take && stroke_nine_out && !s_r.cursor_conn |-> word[css_pkg::SW_END])
        else $error("stroke nine lacks end bit");
    hold_again_a: assert property (
        take && stroke_nine_out |=> ##2 s_r.hold9 && !stroke_nine_out)
        else $error("hold latch not set again");
    end_zero_a: assert property (
        take && word[css_pkg::SW_END] && !s_r.first |=> s_r.cnt == 3'h0 && s_r.end_l)
        else $error("counter not returned to zero");
    single_stroke_a: assert property (
        take && s_r.first && word[css_pkg::SW_END] |=> !first_stroke_out && $stable(s_r.cnt))
        else $error("single stroke disturbed counter");
    stroke_reg_a: assert property (
        take |=> stroke_reg_out == $past(word))
        else $error("stroke register not loaded");
    fetch_kind_a: assert property (
        accept |=> (fetch_buffer_out == $past(buffer_mode_in)) && (fetch_service_out ^ fetch_buffer_out))
        else $error("wrong fetch cycle");
    cursor_word_a: assert property (
        take && s_r.cursor_conn |-> word[css_pkg::SW_X_HI:css_pkg::SW_X_LO]
            == (s_r.cnt[0] ? 3'h0 : 3'h6) && !word[css_pkg::SW_BLANK])
        else $error("cursor stroke wrong");
    margin_a: assert property (
        s_r.fsm == css_pkg::S_NEWL && s_r.y_defl >= s_r.y_sum |=>
            x_defl_out == 10'h000 && y_defl_out == $past(s_r.y_defl) - $past(s_r.y_sum))
        else $error("new line position wrong");
    wrap_top_a: assert property (
        s_r.fsm == css_pkg::S_NEWL && s_r.y_defl < s_r.y_sum |=> y_defl_out == css_pkg::Y_TOP)
        else $error("underflow did not wrap");
    move_done_a: assert property (
        s_r.fsm == css_pkg::S_CHECK && !overflow |=> ##[1:60] deflection_complete_out)
        else $error("deflection never completed");
    x_step_a: assert property (
        s_r.fsm == css_pkg::S_CHECK && !overflow |=> x_defl_out == $past(s_r.x_defl) + $past(s_r.x_sum))
        else $error("x deflection not stepped");
    cursor_defer_a: assert property (
        s_r.fsm == css_pkg::S_DRAW && s_r.end_l && s_r.csr_pend |=> s_r.fsm == css_pkg::S_CURSOR && cursor_connect_out)
        else $error("cursor pass not started");

    cursor_c: cover property (s_r.fsm == css_pkg::S_CURSOR && s_r.end_l);
    nine_c: cover property (take && stroke_nine_out);
    wrap_c: cover property (s_r.fsm == css_pkg::S_NEWL && s_r.y_defl < s_r.y_sum);
    overflow_c: cover property (s_r.fsm == css_pkg::S_CHECK && overflow && !s_r.nl_pend);
    blank_c: cover property (take && word[css_pkg::SW_BLANK]);
endmodule
`default_nettype wire

// ===== logic/css_word_if.sv
// stroke word handshake between the sequencer and its output buffer
// assumes both ends run on the same clock
`default_nettype none
interface css_word_if;
    logic valid;
    logic ready;
    css_pkg::css_word_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== testbench/css_dac_model.sv
// converter-side model: takes stroke words from the block, stalling at random
// assumes the block's clock; a word counts as taken when valid and ready meet
`default_nettype none
module css_dac_model (
    input wire logic clk_in,
    input wire logic valid_in,
    input wire logic [7:0] word_in,
    output logic ready_out,
    output logic got_out,
    output logic [7:0] got_word_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ready_out = 1'b0;
        got_out = 1'b0;
        got_word_out = 8'h00;
    end
    // one word per accepting edge, ready low about a third of the time
    always @(posedge clk_in) begin
        got_out <= valid_in && ready_out;
        got_word_out <= word_in;
        ready_out <= ($urandom % 3) != 0;
    end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench: random characters, cursors, new lines and converter stalls
// assumes css_pkg, the interface and the design modules are compiled first
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dtp = 1'b0;
    logic cv = 1'b0;
    logic ccur = 1'b0;
    logic cnl = 1'b0;
    logic big = 1'b0;
    logic bmode = 1'b0;
    logic se = 1'b0;
    logic [7:0] sw = 8'h00;
    logic sr, sd, fs, fb, fst, nine, cc, dc, dv, db, de, drdy, got;
    logic [2:0] cnt, dx, dy;
    logic [9:0] xd, yd;
    logic [7:0] sreg, gw;
    logic [7:0] expq[$];
    int x = 0;
    int y = 32'h3E0;
    int fails = 0;
    int n_tests = 0;

    css_top uut (
        .sys_clk_in(clk),
        .reset_in(rst),
        .decode_timing_pulse_in(dtp),
        .char_valid_in(cv),
        .char_cursor_in(ccur),
        .char_newline_in(cnl),
        .size_multiplier_latch_in(big),
        .buffer_mode_in(bmode),
        .sample_end_in(se),
        .stroke_x_in(sw[5:3]),
        .stroke_y_in(sw[2:0]),
        .stroke_blank_in(sw[6]),
        .stroke_end_in(sw[7]),
        .dac_ready_in(drdy),
        .sample_ready_out(sr),
        .start_draw_out(sd),
        .fetch_service_out(fs),
        .fetch_buffer_out(fb),
        .first_stroke_out(fst),
        .stroke_count_out(cnt),
        .stroke_nine_out(nine),
        .cursor_connect_out(cc),
        .deflection_complete_out(dc),
        .x_defl_out(xd),
        .y_defl_out(yd),
        .stroke_reg_out(sreg),
        .dac_valid_out(dv),
        .dac_x_out(dx),
        .dac_y_out(dy),
        .dac_blank_out(db),
        .dac_end_out(de)
    );

    css_dac_model dac (
        .clk_in(clk),
        .valid_in(dv),
        .word_in({de, db, dx, dy}),
        .ready_out(drdy),
        .got_out(got),
        .got_word_out(gw)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic bad();
        fails++;
        end_sim();
    endtask

    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_f(input logic g, input logic e);
        chk({9'h000, g}, {9'h000, e});
    endtask

    // sel_dc high waits on deflection complete, low on cursor connect
    task automatic wait_on(input logic sel_dc);
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge clk);
            if ((sel_dc ? dc : cc) === 1'b1) break;
        end
        if (i == 400) bad();
    endtask

    // sampling pulse held until taken while the buffer has room
    task automatic stroke(input logic [7:0] w, input logic [7:0] e);
        int i;
        @(posedge clk);
        sw <= w;
        se <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(negedge clk);
            if (sr === 1'b1) break;
        end
        if (i == 60) bad();
        @(posedge clk);
        se <= 1'b0;
        expq.push_back(e);
        @(negedge clk);
        chk({2'h0, sreg}, {2'h0, e});
    endtask

    // n strokes; n of zero sends a new-line code
    task automatic char(input int n, input logic cur, input logic bg, input logic bm);
        int k;
        int spc;
        int ys;
        logic [7:0] w;
        logic [7:0] e;
        spc = bg ? 32'h018 : 32'h010;
        ys = bg ? 32'h030 : 32'h020;
        @(posedge clk);
        dtp <= 1'b1;
        cv <= 1'b1;
        ccur <= cur;
        cnl <= (n == 0);
        big <= bg;
        bmode <= bm;
        @(posedge clk);
        dtp <= 1'b0;
        cv <= 1'b0;
        @(negedge clk);
        chk_f(sd, n != 0);
        chk_f(fb, bm);
        chk_f(fs, !bm);
        chk_f(dc, 1'b0);
        if (n != 0) chk_f(fst, 1'b1);
        for (k = 1; k <= n; k++) begin
            w = 8'($urandom);
            w[7] = (k == n) && (n < 9);
            e = w;
            if (k == 9) begin
                chk_f(nine, 1'b1);
                e = {1'b1, w[6], 6'h00};
            end
            stroke(w, e);
            if (k == 1) chk_f(fst, 1'b0);
            chk({7'h00, cnt}, (k == n) ? 10'h000 : 10'(k % 8));
        end
        if (n == 9) begin
            repeat (2) @(negedge clk);
            chk_f(nine, 1'b0);
        end
        if (cur) begin
            wait_on(1'b0);
            chk_f(cc, 1'b1);
            for (k = 1; k <= 6; k++) begin
                w = 8'($urandom);
                stroke(w, {k == 6, 1'b0, k[0] ? 3'h6 : 3'h0, 3'h0});
            end
        end
        wait_on(1'b1);
        if (n == 0 || x + spc > 32'h3F0) begin
            y = (y < ys) ? 32'h3E0 : y - ys;
            x = 0;
        end else begin
            x = x + spc;
        end
        chk(xd, x[9:0]);
        chk(yd, y[9:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (got === 1'b1) begin
            if (expq.size() == 0) chk({2'h0, gw}, 10'h3FF);
            else chk({2'h0, gw}, {2'h0, expq.pop_front()});
        end
    end

    initial begin
        forever #25 clk = ~clk;
    end

    initial begin
        int i;
        i = $urandom(64338);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_f(dc, 1'b1);
        chk(xd, 10'h000);
        chk(yd, 10'h3E0);
        chk({7'h00, cnt}, 10'h000);
        chk_f(fst, 1'b0);
        chk_f(dv, 1'b0);
        char(9, 1'b0, 1'b0, 1'b1);
        char(1, 1'b1, 1'b1, 1'b0);
        for (i = 0; i < 120; i++) begin
            char($urandom_range(9, 1), ($urandom % 6) == 0, 1'($urandom % 2), 1'($urandom % 2));
        end
        for (i = 0; i < 34; i++) begin
            char(0, 1'b0, i[1], i[0]);
        end
        for (i = 0; i < 100 && expq.size() > 0; i++) begin
            @(negedge clk);
        end
        chk(10'(expq.size()), 10'h000);
        end_sim();
    end
endmodule
`default_nettype wire
